// ### pkg/sscp_pkg.sv
// package with register map, fields, states and carriers of the suspend and sink port
`default_nettype none
package sscp_pkg;
  localparam int DATA_W = 8;
  localparam int PIN_N = 8;
  localparam int LEVEL_W = 4;
  localparam int PIN_IDX_W = 3;
  // io addresses
  localparam logic [7:0] ADDR_SINK_PORT_DATA = 8'h30;
  localparam logic [7:0] ADDR_SINK_PORT_IRQ_ENABLE = 8'h31;
  localparam logic [7:0] ADDR_SINK_PORT_IRQ_POLARITY = 8'h32;
  localparam logic [7:0] ADDR_SINK_LEVEL_BASE = 8'h38;
  localparam logic [4:0] ADDR_SINK_LEVEL_PAGE = 5'h07;
  localparam logic [7:0] ADDR_PROCESSOR_STATUS_CONTROL = 8'hFF;
  // processor status and control fields
  localparam int PSC_RUN_BIT = 0;
  localparam int PSC_GIE_BIT = 2;
  localparam int PSC_SUSPEND_BIT = 3;
  localparam int PSC_IRQ_SENSE_BIT = 7;
  // reset values
  localparam logic [7:0] SINK_PORT_DATA_RESET = 8'hFF;
  localparam logic [7:0] SINK_PORT_IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SINK_PORT_IRQ_POLARITY_RESET = 8'h00;
  localparam logic [3:0] SINK_LEVEL_RESET = 4'h0;
  localparam logic RUN_RESET = 1'b1;
  localparam logic SUSPEND_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_MS = 1;
  localparam int NS_PER_MS = 1000000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 32;
  // suspend sequencer states, gray along run, suspended, osc wait, settle
  typedef enum logic [1:0] {
    SSCP_RUN = 2'h0,
    SSCP_SUSPENDED = 2'h1,
    SSCP_OSC_WAIT = 2'h3,
    SSCP_SETTLE = 2'h2
  } sscp_state_type;
  // io write/read request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sscp_io_req_type;
  // pad controls of one sink port pin
  typedef struct packed {
    logic pullup_en;
    logic sink_en;
    logic [LEVEL_W-1:0] level;
  } sscp_pad_type;
  // clock and power gating of the rest of the chip
  typedef struct packed {
    logic osc_enable;
    logic pll_enable;
    logic timer_enable;
    logic watchdog_timer_enable;
    logic logic_enable;
    logic core_hold;
  } sscp_power_type;
endpackage : sscp_pkg
`default_nettype wire

// ### rtl/sscp_level_bank.sv
// bank of eight write-only sink-level registers with registered outputs
`timescale 1ns/1ns
`default_nettype none
module sscp_level_bank
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [sscp_pkg::PIN_IDX_W-1:0] wr_idx,
  input wire logic [sscp_pkg::LEVEL_W-1:0] wr_level,
  output logic [sscp_pkg::PIN_N-1:0][sscp_pkg::LEVEL_W-1:0] levels
);
  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < sscp_pkg::PIN_N; g++)
    begin : g_entry
      // one entry per pin
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          levels[g] <= sscp_pkg::SINK_LEVEL_RESET;
        end
        else if (wr_en && (wr_idx == sscp_pkg::PIN_IDX_W'(g)))
        begin
          levels[g] <= wr_level;
        end
      end
    end
  endgenerate
endmodule : sscp_level_bank
`default_nettype wire

// ### rtl/sscp_top.sv
// suspend control and programmable sink-current port
//
// How it works
// - Setting the suspend bit turns off all logic but GPIO interrupt and USB receiver.
// - While suspended, oscillator, PLL, free-running timer and watchdog timer are stopped.
// - Only an enabled GPIO interrupt or USB bus activity wakes the device.
// - On wake, restart oscillator, hold core until 1 ms after oscillator is stable.
// - Core runs the instruction after the suspending write before any interrupt.
// - Data bit one: sink off, pin pulled high by pull-up.
// - Data bit zero: sink on, pull-up off, pin driven low.
// - Each pin's sink strength is one of 16 levels from its own register.
// - In suspend the whole sink circuitry is off; low pins float.
// - Sink port data at 0x30, eight read/write bits, reset to all ones.
// - Write-only interrupt enable register at 0x31, one bit per pin.
// - Write-only interrupt polarity register at 0x32, one bit per pin.
// - Eight write-only sink-level registers at 0x38 to 0x3F.
// - Processor status and control register, read/write at 0xFF.
`timescale 1ns/1ns
`default_nettype none
module sscp_top
#(
  parameter int SETTLE_CYCLES = sscp_pkg::SETTLE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire sscp_pkg::sscp_io_req_type io_req,
  output logic [sscp_pkg::DATA_W-1:0] io_rdata,
  input wire logic core_instr_done,
  input wire logic core_gie,
  input wire logic core_irq_sense,
  input wire logic gpio_irq_wake,
  input wire logic usb_activity,
  input wire logic osc_stable,
  input wire logic [sscp_pkg::PIN_N-1:0] pin_in,
  output sscp_pkg::sscp_pad_type [sscp_pkg::PIN_N-1:0] pad,
  output sscp_pkg::sscp_power_type power,
  output logic sink_irq,
  output logic irq_block
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  function automatic logic level_hit(input logic [7:0] addr);
    level_hit = (addr[7:3] == sscp_pkg::ADDR_SINK_LEVEL_PAGE);
  endfunction : level_hit

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [sscp_pkg::PIN_N-1:0] sink_port_data;
  logic [sscp_pkg::PIN_N-1:0] sink_port_irq_enable;
  logic [sscp_pkg::PIN_N-1:0] sink_port_irq_polarity;
  logic [sscp_pkg::PIN_N-1:0][sscp_pkg::LEVEL_W-1:0] levels;
  logic run_bit;
  logic suspend_bit;
  sscp_pkg::sscp_state_type state;
  sscp_pkg::sscp_state_type next_state;
  logic [sscp_pkg::SETTLE_W-1:0] settle_count;
  logic [sscp_pkg::PIN_N-1:0] pin_meta;
  logic [sscp_pkg::PIN_N-1:0] pin_sync;
  logic [2:0] async_meta;
  logic [2:0] async_sync;
  logic gpio_wake_s;
  logic usb_activity_s;
  logic osc_stable_s;
  logic wr_psc;
  logic wake_event;
  logic suspended;
  logic next_sink_irq;
  logic [sscp_pkg::DATA_W-1:0] next_rdata;

  assign gpio_wake_s = async_sync[0];
  assign usb_activity_s = async_sync[1];
  assign osc_stable_s = async_sync[2];
  assign wr_psc = io_req.wr && hit(io_req.addr, sscp_pkg::ADDR_PROCESSOR_STATUS_CONTROL);
  assign suspended = (state != sscp_pkg::SSCP_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for pins and async status inputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      async_meta <= '0;
      async_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      async_meta <= {osc_stable, usb_activity, gpio_irq_wake};
      async_sync <= async_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sink port data register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sink_port_data <= sscp_pkg::SINK_PORT_DATA_RESET;
    end
    else if (io_req.wr && hit(io_req.addr, sscp_pkg::ADDR_SINK_PORT_DATA))
    begin
      sink_port_data <= io_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enable and polarity registers, write only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sink_port_irq_enable <= sscp_pkg::SINK_PORT_IRQ_ENABLE_RESET;
    end
    else if (io_req.wr && hit(io_req.addr, sscp_pkg::ADDR_SINK_PORT_IRQ_ENABLE))
    begin
      sink_port_irq_enable <= io_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sink_port_irq_polarity <= sscp_pkg::SINK_PORT_IRQ_POLARITY_RESET;
    end
    else if (io_req.wr && hit(io_req.addr, sscp_pkg::ADDR_SINK_PORT_IRQ_POLARITY))
    begin
      sink_port_irq_polarity <= io_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sink-level registers
  sscp_level_bank u_level_bank
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(io_req.wr && level_hit(io_req.addr)),
    .wr_idx(io_req.addr[sscp_pkg::PIN_IDX_W-1:0]),
    .wr_level(io_req.wdata[sscp_pkg::LEVEL_W-1:0]),
    .levels(levels)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-pin interrupt, level sensitive with programmable polarity
  always_comb
  begin
    next_sink_irq = |(sink_port_irq_enable & ~(pin_sync ^ sink_port_irq_polarity));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sink_irq <= 1'b0;
    end
    else
    begin
      sink_irq <= next_sink_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources stay alive in suspend
  assign wake_event = gpio_wake_s || next_sink_irq || usb_activity_s;

  ////////////////////////////////////////////////////////////////////////////
  // processor status and control, run and suspend bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      run_bit <= sscp_pkg::RUN_RESET;
    end
    else if (wr_psc)
    begin
      run_bit <= io_req.wdata[sscp_pkg::PSC_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      suspend_bit <= sscp_pkg::SUSPEND_RESET;
    end
    else if (wr_psc && io_req.wdata[sscp_pkg::PSC_SUSPEND_BIT])
    begin
      suspend_bit <= 1'b1;
    end
    else if (state == sscp_pkg::SSCP_SUSPENDED && next_state != sscp_pkg::SSCP_SUSPENDED)
    begin
      suspend_bit <= 1'b0;
    end
    else if (wr_psc)
    begin
      suspend_bit <= io_req.wdata[sscp_pkg::PSC_SUSPEND_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // suspend sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      sscp_pkg::SSCP_RUN:
      begin
        if (wr_psc && io_req.wdata[sscp_pkg::PSC_SUSPEND_BIT])
        begin
          next_state = sscp_pkg::SSCP_SUSPENDED;
        end
      end
      sscp_pkg::SSCP_SUSPENDED:
      begin
        if (wake_event && run_bit)
        begin
          next_state = sscp_pkg::SSCP_OSC_WAIT;
        end
      end
      sscp_pkg::SSCP_OSC_WAIT:
      begin
        if (osc_stable_s)
        begin
          next_state = sscp_pkg::SSCP_SETTLE;
        end
      end
      sscp_pkg::SSCP_SETTLE:
      begin
        if (settle_count == sscp_pkg::SETTLE_W'(SETTLE_CYCLES - 1))
        begin
          next_state = sscp_pkg::SSCP_RUN;
        end
      end
      default:
      begin
        next_state = sscp_pkg::SSCP_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= sscp_pkg::SSCP_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settle counter, 1 ms after the oscillator is stable
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      settle_count <= '0;
    end
    else if (state == sscp_pkg::SSCP_SETTLE)
    begin
      settle_count <= settle_count + sscp_pkg::SETTLE_W'(1);
    end
    else
    begin
      settle_count <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and power gating
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      power <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end
    else
    begin
      power.osc_enable <= (next_state != sscp_pkg::SSCP_SUSPENDED);
      power.pll_enable <= (next_state != sscp_pkg::SSCP_SUSPENDED);
      power.timer_enable <= (next_state == sscp_pkg::SSCP_RUN);
      power.watchdog_timer_enable <= (next_state == sscp_pkg::SSCP_RUN);
      power.logic_enable <= (next_state == sscp_pkg::SSCP_RUN);
      power.core_hold <= (next_state != sscp_pkg::SSCP_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt service held off until the instruction after the suspend write ends
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_block <= 1'b0;
    end
    else if (next_state != sscp_pkg::SSCP_RUN)
    begin
      irq_block <= 1'b1;
    end
    else if (!power.core_hold && core_instr_done)
    begin
      irq_block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive, sink disabled while suspended, settings retained
  genvar g;
  generate
    for (g = 0; g < sscp_pkg::PIN_N; g++)
    begin : g_pad
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          pad[g] <= '{1'b1, 1'b0, sscp_pkg::SINK_LEVEL_RESET};
        end
        else
        begin
          pad[g].pullup_en <= sink_port_data[g];
          pad[g].sink_en <= !sink_port_data[g] && !suspend_bit && !suspended;
          pad[g].level <= levels[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data, write-only and unmapped addresses read zero
  always_comb
  begin
    next_rdata = sscp_pkg::READ_ZERO;
    if (hit(io_req.addr, sscp_pkg::ADDR_SINK_PORT_DATA))
    begin
      next_rdata = sink_port_data;
    end
    else if (hit(io_req.addr, sscp_pkg::ADDR_PROCESSOR_STATUS_CONTROL))
    begin
      next_rdata[sscp_pkg::PSC_RUN_BIT] = run_bit;
      next_rdata[sscp_pkg::PSC_GIE_BIT] = core_gie;
      next_rdata[sscp_pkg::PSC_SUSPEND_BIT] = suspend_bit;
      next_rdata[sscp_pkg::PSC_IRQ_SENSE_BIT] = core_irq_sense;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      io_rdata <= sscp_pkg::READ_ZERO;
    end
    else if (io_req.rd)
    begin
      io_rdata <= next_rdata;
    end
  end
endmodule : sscp_top
`default_nettype wire

// ### tb/sscp_partner.sv
// far side model: oscillator settling and external loads on the sink pins
`timescale 1ns/1ns
`default_nettype none
module sscp_partner
#(
  parameter int OSC_DELAY = 4
)
(
  input wire logic ref_clk,
  input wire sscp_pkg::sscp_pad_type [sscp_pkg::PIN_N-1:0] pad,
  input wire sscp_pkg::sscp_power_type power,
  output logic osc_stable,
  output logic [sscp_pkg::PIN_N-1:0] pin_in
);
  int cnt = 0;
  logic flip = 1'b0;
  always @(posedge ref_clk)
  begin
    flip <= ~flip;
    if (!power.osc_enable)
      cnt <= 0;
    else if (cnt < OSC_DELAY)
      cnt <= cnt + 1;
  end
  assign osc_stable = (cnt == OSC_DELAY);
  // a floating pin toggles so no stale level is seen
  always_comb
    for (int i = 0; i < sscp_pkg::PIN_N; i++)
      pin_in[i] = pad[i].pullup_en ? 1'b1 : pad[i].sink_en ? 1'b0 : flip ^ i[0];
endmodule : sscp_partner
`default_nettype wire

// ### tb/sscp_top_assertions.sv
// checker on the ports of the suspend and sink port
`timescale 1ns/1ns
`default_nettype none
module sscp_checker
#(
  parameter int SETTLE_CYCLES = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire sscp_pkg::sscp_io_req_type io_req,
  input wire logic [sscp_pkg::DATA_W-1:0] io_rdata,
  input wire logic core_instr_done,
  input wire logic core_gie,
  input wire logic core_irq_sense,
  input wire sscp_pkg::sscp_pad_type [sscp_pkg::PIN_N-1:0] pad,
  input wire sscp_pkg::sscp_power_type power,
  input wire logic irq_block
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_enter;
    io_req.wr && io_req.addr == sscp_pkg::ADDR_PROCESSOR_STATUS_CONTROL && io_req.wdata[3];
  endsequence
  sequence s_gated;
    !power.osc_enable && !power.pll_enable && power.core_hold && !pad[0].sink_en;
  endsequence
  a_suspend_gates: assert property (s_enter |-> ##2 s_gated)
    else $error("suspend did not gate clocks");
  a_held_gated: assert property (power.core_hold |->
    !power.timer_enable && !power.watchdog_timer_enable && !power.logic_enable)
    else $error("timers run while core held");
  a_release_late: assert property ($fell(power.core_hold) |->
    power.osc_enable && $past(power.osc_enable, 8))
    else $error("core released too early");
  a_data_zero: assert property ((io_req.wr && io_req.addr == 8'h30 && !io_req.wdata[0]
    && power.logic_enable) ##1 !io_req.wr |=> pad[0].sink_en && !pad[0].pullup_en)
    else $error("zero bit did not sink");
  a_data_one: assert property (io_req.wr && io_req.addr == 8'h30 && io_req.wdata[0]
    |-> ##2 !pad[0].sink_en && pad[0].pullup_en)
    else $error("one bit did not pull up");
  a_status_read: assert property (io_req.rd && io_req.addr == 8'hFF |=>
    io_rdata[7] == $past(core_irq_sense) && io_rdata[2] == $past(core_gie)
    && io_rdata[6:4] == 3'h0 && io_rdata[1] == 1'b0)
    else $error("status read wrong");
  a_wo_zero: assert property (io_req.rd && (io_req.addr == 8'h31
    || io_req.addr == 8'h32 || io_req.addr[7:3] == sscp_pkg::ADDR_SINK_LEVEL_PAGE)
    |=> io_rdata == 8'h00)
    else $error("write-only register read back");
  a_irq_hold: assert property (irq_block && !core_instr_done |=> irq_block)
    else $error("interrupt block dropped early");
endmodule : sscp_checker
bind sscp_top sscp_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) sscp_checker_i (.ref_clk(ref_clk),
  .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .core_instr_done(core_instr_done),
  .core_gie(core_gie), .core_irq_sense(core_irq_sense), .pad(pad), .power(power),
  .irq_block(irq_block));
`default_nettype wire

// ### tb/sscp_top_test.sv
// testbench of the suspend and sink port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module sscp_top_test;
  logic ref_clk, rst, core_instr_done, core_gie, core_irq_sense;
  logic gpio_irq_wake, usb_activity, osc_stable, sink_irq, irq_block;
  logic [7:0] io_rdata, pin_in;
  sscp_pkg::sscp_io_req_type io_req;
  sscp_pkg::sscp_pad_type [7:0] pad;
  sscp_pkg::sscp_power_type power;
  int err_count = 0;
  int tests_run = 0;
  int k;
  sscp_top #(.SETTLE_CYCLES(8)) sscp_top_i (.ref_clk(ref_clk), .rst(rst), .io_req(io_req),
    .io_rdata(io_rdata), .core_instr_done(core_instr_done), .core_gie(core_gie),
    .core_irq_sense(core_irq_sense), .gpio_irq_wake(gpio_irq_wake),
    .usb_activity(usb_activity), .osc_stable(osc_stable), .pin_in(pin_in), .pad(pad),
    .power(power), .sink_irq(sink_irq), .irq_block(irq_block));
  sscp_partner sscp_partner_i (.ref_clk(ref_clk), .pad(pad), .power(power),
    .osc_stable(osc_stable), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    io_req = '{a, d, 1'b1, 1'b0};
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    io_req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge ref_clk);
    `CHK(io_rdata, e)
  endtask : rd
  task idle(input int n);
    io_req = '0;
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    err_count++;
    report_and_stop;
  end
  initial
  begin
    rst = 1'b1;
    io_req = '0;
    core_instr_done = 1'b0;
    core_gie = 1'b1;
    core_irq_sense = 1'b0;
    gpio_irq_wake = 1'b0;
    usb_activity = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    rd(8'h30, 8'hFF);
    rd(8'hFF, 8'h05);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h3F, 8'h00);
    rd(8'h40, 8'h00);
    core_irq_sense = 1'b1;
    rd(8'hFF, 8'h85);
    core_irq_sense = 1'b0;
    $display("test reset_map done");
    wr(8'h30, 8'h0E);
    idle(1);
    `CHK({pad[0].pullup_en, pad[0].sink_en, pad[1].pullup_en, pad[1].sink_en}, 4'b0110)
    rd(8'h30, 8'h0E);
    for (k = 0; k < 8; k++)
      wr(8'(56 + k), 8'(8 + k));
    idle(3);
    for (k = 0; k < 8; k++)
      `CHK(pad[k].level, 4'(8 + k))
    wr(8'h31, 8'h01);
    wr(8'h32, 8'h00);
    idle(5);
    `CHK(sink_irq, 1'b1)
    wr(8'h32, 8'h01);
    idle(5);
    `CHK(sink_irq, 1'b0)
    wr(8'h31, 8'h00);
    rd(8'h31, 8'h00);
    $display("test data_level done");
    wr(8'hFF, 8'h09);
    idle(3);
    `CHK(power, 6'b000001)
    `CHK({pad[4].pullup_en, pad[4].sink_en}, 2'b00)
    idle(20);
    `CHK(power.core_hold, 1'b1)
    gpio_irq_wake = 1'b1;
    k = 0;
    while (!power.osc_enable && k < 20)
    begin
      @(negedge ref_clk);
      k++;
    end
    `CHK(k, 3)
    gpio_irq_wake = 1'b0;
    k = 0;
    while (!osc_stable && k < 20)
    begin
      @(negedge ref_clk);
      k++;
    end
    k = 0;
    while (power.core_hold && k < 50)
    begin
      @(negedge ref_clk);
      k++;
    end
    `CHK(k, 11)
    idle(2);
    `CHK({pad[4].pullup_en, pad[4].sink_en, power}, 8'b01111110)
    `CHK(pad[7].level, 4'hF)
    `CHK(irq_block, 1'b1)
    core_instr_done = 1'b1;
    @(negedge ref_clk);
    core_instr_done = 1'b0;
    @(negedge ref_clk);
    `CHK(irq_block, 1'b0)
    rd(8'hFF, 8'h05);
    $display("test suspend_wake done");
    wr(8'h30, 8'hFF);
    wr(8'hFF, 8'h08);
    idle(3);
    usb_activity = 1'b1;
    idle(20);
    `CHK(power.core_hold, 1'b1)
    usb_activity = 1'b0;
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    `CHK(power, 6'b111110)
    rd(8'h30, 8'hFF);
    $display("test run_clear done");
    report_and_stop;
  end
endmodule : sscp_top_test
`default_nettype wire
